// >>> hw/lsc_pkg.sv
// Constants, pin bundle and bus states for the module low-speed control block.
// Assumes a single 100 MHz core clock; all pins arrive asynchronously.
package lsc_pkg;

	// Memory map geometry and locally held bytes
	localparam int          MAP_DEPTH        = 128;
	localparam int          MAP_AW           = 7;
	localparam logic [6:0]  STATUS_OFS       = 7'h02;
	localparam logic [6:0]  FLAG_OFS         = 7'h03;
	localparam logic [6:0]  MASK_OFS         = 7'h04;
	localparam int          STATUS_DNR_BIT   = 0;
	localparam int          STATUS_LP_BIT    = 1;
	localparam int          FLAG_DONE_BIT    = 0;
	localparam logic [7:0]  MAP_RESET_VAL    = 8'h00;
	localparam int          FAULT_W          = 7;

	// Bus address; value is arbitrary
	localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h50;
	localparam logic [3:0]  BYTE_BITS        = 4'h8;

	// Timing
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          RESET_MIN_NS     = 1000;
	localparam int          INIT_NS          = 10000;
	localparam int          RESET_MIN_CYC    = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          INIT_CYC         = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W            = 12;

	// Pin bundle; idle level of every pin is high
	typedef struct packed {
		logic scl;
		logic sda;
		logic select_n;
		logic reset_n;
		logic low_power;
	} pin_in_s;
	localparam logic [4:0]  PIN_IDLE         = 5'h1f;

	typedef enum {
		BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_PTR, BUS_PTR_ACK,
		BUS_WDATA, BUS_WACK, BUS_RDATA, BUS_RACK
	} bus_state_e;

endpackage : lsc_pkg

// >>> hw/pin_sync.sv
// Three-stage synchroniser for asynchronous pins.
// Output follows only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int             W        = 1,
	parameter logic [W-1:0]   IDLE_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Pins in, clean levels out
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire  [W-1:0] agree = ~(s2_r ^ s3_r);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= IDLE_VAL;
			s2_r <= IDLE_VAL;
			s3_r <= IDLE_VAL;
			dout <= IDLE_VAL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dout <= (agree & s3_r) | (~agree & dout);
		end
	end
endmodule : pin_sync
`default_nettype wire

// >>> hw/module_low_speed_control.sv
// Low-speed management logic of a pluggable module: two-wire slave with a
// small memory map, module reset and init sequencing, attention and presence.
// Assumes host pull-ups on SDA, SCL, attention and presence lines.
//
// Overview of operation
// - Answer bus only while select held low
// - Long reset pulse restores all defaults
// - Completion interrupt with not-ready bit cleared
// - Power-up posts completion interrupt unprompted
// - Low-power pin sets power limit
// - Presence line pulled to ground
// - Attention low flags fault or critical status
// - Attention only pulled low or released
// - Map readable and writable over bus
`timescale 1ns/1ps
`default_nettype none
module module_low_speed_control import lsc_pkg::*; #(
	parameter logic [6:0] DEV_ADDR  = DEV_ADDR_DEFAULT,
	parameter int         RESET_MIN = RESET_MIN_CYC,
	parameter int         INIT_TIME = INIT_CYC
) (
	// Clock and reset
	input  wire logic               CORE_CLK,
	input  wire logic               RST,
	// Host control pins
	input  wire logic               MODULE_SELECT_N,
	input  wire logic               MODULE_RESET_N,
	input  wire logic               LOW_POWER_SELECT,
	// Two-wire serial bus
	input  wire logic               SCL,
	input  wire logic               SDA_IN,
	output logic                    SDA_OUT,
	output logic                    SDA_OE,
	// Open-drain status lines
	output logic                    ATTENTION_N_OUT,
	output logic                    ATTENTION_N_OE,
	output logic                    PRESENCE_N_OUT,
	output logic                    PRESENCE_N_OE,
	// Module internals
	input  wire logic [FAULT_W-1:0] FAULT_EVENT,
	output logic                    POWER_LIMIT_LOW,
	output logic                    DATA_NOT_READY
);

	pin_in_s pins_raw;
	pin_in_s pins;

	assign pins_raw = '{scl: SCL, sda: SDA_IN, select_n: MODULE_SELECT_N,
		reset_n: MODULE_RESET_N, low_power: LOW_POWER_SELECT};

	pin_sync #(
		.W        ($bits(pin_in_s)),
		.IDLE_VAL (PIN_IDLE)
	) u_sync (
		.clk  (CORE_CLK),
		.rst  (RST),
		.din  (pins_raw),
		.dout (pins)
	);

	// State
	bus_state_e              st_r;
	bus_state_e              st_nxt;
	logic [3:0]              cnt_r;
	logic [3:0]              cnt_nxt;
	logic [7:0]              sh_r;
	logic [7:0]              sh_nxt;
	logic [MAP_AW-1:0]       ptr_r;
	logic [MAP_AW-1:0]       ptr_nxt;
	logic                    rw_r;
	logic                    rw_nxt;
	logic                    ack_r;
	logic                    ack_nxt;
	logic                    drv_r;
	logic                    drv_nxt;
	logic                    wr_en;
	logic                    ld_en;
	logic                    scl_q_r;
	logic                    sda_q_r;
	logic [CNT_W-1:0]        low_cnt_r;
	logic                    wipe_r;
	logic [CNT_W-1:0]        init_cnt_r;
	logic                    dnr_r;
	logic [7:0]              flags_r;
	logic [7:0]              mem_r [MAP_DEPTH];
	logic                    att_r;
	logic                    lp_r;

	// Pin events
	wire sel       = ~pins.select_n;
	wire scl_rise  = pins.scl & ~scl_q_r;
	wire scl_fall  = ~pins.scl & scl_q_r;
	wire bus_start = scl_q_r & pins.scl & sda_q_r & ~pins.sda;
	wire bus_stop  = scl_q_r & pins.scl & ~sda_q_r & pins.sda;

	// Reset pulse qualification
	wire reset_low = ~pins.reset_n;
	wire reset_hit = reset_low & (low_cnt_r == CNT_W'(RESET_MIN));
	wire init_end  = dnr_r & ~wipe_r & (init_cnt_r == CNT_W'(INIT_TIME - 1));

	function automatic logic writable(input logic [MAP_AW-1:0] idx);
		return (idx != STATUS_OFS) && (idx != FLAG_OFS);
	endfunction : writable

	function automatic logic [7:0] map_read(input logic [MAP_AW-1:0] idx);
		logic [7:0] v;
		v = mem_r[idx];
		if (idx == STATUS_OFS) begin
			v = '0;
			v[STATUS_DNR_BIT] = dnr_r;
			v[STATUS_LP_BIT]  = lp_r;
		end else if (idx == FLAG_OFS) begin
			v = flags_r;
		end
		return v;
	endfunction : map_read

	// Process, not a net: a net would miss map and flag updates behind the call
	logic [7:0] map_rd;
	always_comb begin
		map_rd = map_read(ptr_r);
	end
	wire       flag_clr  = ld_en & (ptr_r == FLAG_OFS);
	wire [7:0] flag_set  = {FAULT_EVENT, init_end};
	wire [7:0] flags_nxt = (flags_r & ~{8{flag_clr}}) | flag_set;
	wire       byte_done = (cnt_r == BYTE_BITS);

	// Bus slave next state
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		sh_nxt  = sh_r;
		ptr_nxt = ptr_r;
		rw_nxt  = rw_r;
		ack_nxt = ack_r;
		drv_nxt = drv_r;
		wr_en   = 1'b0;
		ld_en   = 1'b0;
		if (wipe_r || !sel) begin
			st_nxt  = BUS_IDLE;
			drv_nxt = 1'b0;
		end else if (bus_start) begin
			st_nxt  = BUS_ADDR;
			cnt_nxt = '0;
			drv_nxt = 1'b0;
		end else if (bus_stop) begin
			st_nxt  = BUS_IDLE;
			drv_nxt = 1'b0;
		end else if (scl_rise) begin
			unique case (st_r)
				BUS_ADDR, BUS_PTR, BUS_WDATA: begin
					sh_nxt  = {sh_r[6:0], pins.sda};
					cnt_nxt = cnt_r + 4'h1;
				end
				BUS_RDATA: cnt_nxt = cnt_r + 4'h1;
				BUS_RACK:  ack_nxt = ~pins.sda;
				BUS_IDLE, BUS_ADDR_ACK, BUS_PTR_ACK, BUS_WACK: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (st_r)
				BUS_IDLE: begin
				end
				BUS_ADDR: if (byte_done) begin
					if (sh_r[7:1] == DEV_ADDR) begin
						drv_nxt = 1'b1;
						rw_nxt  = sh_r[0];
						st_nxt  = BUS_ADDR_ACK;
					end else begin
						st_nxt  = BUS_IDLE;
					end
				end
				BUS_ADDR_ACK: begin
					cnt_nxt = '0;
					if (rw_r) begin
						ld_en   = 1'b1;
						sh_nxt  = map_rd;
						drv_nxt = ~map_rd[7];
						ptr_nxt = ptr_r + 1'b1;
						st_nxt  = BUS_RDATA;
					end else begin
						drv_nxt = 1'b0;
						st_nxt  = BUS_PTR;
					end
				end
				BUS_PTR: if (byte_done) begin
					ptr_nxt = sh_r[MAP_AW-1:0];
					drv_nxt = 1'b1;
					st_nxt  = BUS_PTR_ACK;
				end
				BUS_PTR_ACK, BUS_WACK: begin
					drv_nxt = 1'b0;
					cnt_nxt = '0;
					st_nxt  = BUS_WDATA;
				end
				BUS_WDATA: if (byte_done) begin
					wr_en   = 1'b1;
					ptr_nxt = ptr_r + 1'b1;
					drv_nxt = 1'b1;
					st_nxt  = BUS_WACK;
				end
				BUS_RDATA: begin
					if (byte_done) begin
						drv_nxt = 1'b0;
						st_nxt  = BUS_RACK;
					end else begin
						sh_nxt  = {sh_r[6:0], 1'b0};
						drv_nxt = ~sh_r[6];
					end
				end
				BUS_RACK: begin
					cnt_nxt = '0;
					if (ack_r) begin
						ld_en   = 1'b1;
						sh_nxt  = map_rd;
						drv_nxt = ~map_rd[7];
						ptr_nxt = ptr_r + 1'b1;
						st_nxt  = BUS_RDATA;
					end else begin
						st_nxt  = BUS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_r    <= BUS_IDLE;
			cnt_r   <= '0;
			sh_r    <= '0;
			ptr_r   <= '0;
			rw_r    <= 1'b0;
			ack_r   <= 1'b0;
			drv_r   <= 1'b0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			ptr_r   <= wipe_r ? '0 : ptr_nxt;
			rw_r    <= rw_nxt;
			ack_r   <= ack_nxt;
			drv_r   <= drv_nxt;
			scl_q_r <= pins.scl;
			sda_q_r <= pins.sda;
		end
	end

	// Reset pulse filter: wipe holds while the pin stays low
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			low_cnt_r <= '0;
			wipe_r    <= 1'b0;
		end else begin
			low_cnt_r <= !reset_low ? '0 : (reset_hit ? low_cnt_r : low_cnt_r + 1'b1);
			wipe_r    <= reset_low & (wipe_r | reset_hit);
		end
	end

	// Init sequence; power-up enters it just like a pin reset
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			dnr_r      <= 1'b1;
			init_cnt_r <= '0;
			flags_r    <= '0;
		end else begin
			if (wipe_r) begin
				dnr_r      <= 1'b1;
				init_cnt_r <= '0;
			end else if (init_end) begin
				dnr_r      <= 1'b0;
			end else if (dnr_r) begin
				init_cnt_r <= init_cnt_r + 1'b1;
			end
			flags_r <= wipe_r ? '0 : flags_nxt;
		end
	end

	// Map storage; every byte returns to its default on either reset
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < MAP_DEPTH; i++) begin
				mem_r[i] <= MAP_RESET_VAL;
			end
		end else if (wipe_r) begin
			for (int i = 0; i < MAP_DEPTH; i++) begin
				mem_r[i] <= MAP_RESET_VAL;
			end
		end else if (wr_en && writable(ptr_r)) begin
			mem_r[ptr_r] <= sh_r;
		end
	end

	// Registered pin drivers
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			att_r <= 1'b0;
			lp_r  <= 1'b1;
		end else begin
			att_r <= |(flags_r & ~mem_r[MASK_OFS]);
			lp_r  <= pins.low_power;
		end
	end

	// Open-drain lines only ever pull low; the host supplies the high level
	assign SDA_OUT         = 1'b0;
	assign SDA_OE          = drv_r;
	assign ATTENTION_N_OUT = 1'b0;
	assign ATTENTION_N_OE  = att_r;
	assign PRESENCE_N_OUT  = 1'b0;
	assign PRESENCE_N_OE   = 1'b1;
	assign POWER_LIMIT_LOW = lp_r;
	assign DATA_NOT_READY  = dnr_r;

endmodule : module_low_speed_control
`default_nettype wire

// >>> dv/host_master.sv
// Host-side two-wire master: makes SCL and pulls SDA low on request.
// Assumes the bench resolves the SDA wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module host_master (
	// Bus wires
	output logic      scl,
	output logic      sda_drv_n,
	input  wire logic sda
);
	initial begin
		scl = 1'b1; // Clock stands still high between frames
		sda_drv_n = 1'b1;
	end
	task automatic start();
		sda_drv_n = 1'b1;
		// Slave may still hold an ACK; let it go before SCL rises, else a stop
		#80 scl = 1'b1;
		#80 sda_drv_n = 1'b0;
		#80 scl = 1'b0;
	endtask : start
	task automatic stop();
		#20 sda_drv_n = 1'b0;
		#60 scl = 1'b1;
		#80 sda_drv_n = 1'b1;
		#80;
	endtask : stop
	// Data moves only while SCL is low
	task automatic bit_io(input logic b, output logic got);
		#20 sda_drv_n = b;
		#60 scl = 1'b1;
		#80 got = sda;
		scl = 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] w, input logic last, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(last, ack);
	endtask : byte_io
endmodule : host_master
`default_nettype wire

// >>> dv/lsc_props.sv
// Concurrent checks on the low-speed control pins.
// Bound to the design top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module lsc_props import lsc_pkg::*; #(
	parameter int RESET_MIN = RESET_MIN_CYC
) (
	// Clock and reset
	input wire logic               CORE_CLK,
	input wire logic               RST,
	// Host pins
	input wire logic               MODULE_SELECT_N,
	input wire logic               MODULE_RESET_N,
	input wire logic               LOW_POWER_SELECT,
	// Line drivers
	input wire logic               SDA_OUT,
	input wire logic               SDA_OE,
	input wire logic               ATTENTION_N_OUT,
	input wire logic               ATTENTION_N_OE,
	input wire logic               PRESENCE_N_OUT,
	input wire logic               PRESENCE_N_OE,
	// Internals
	input wire logic [FAULT_W-1:0] FAULT_EVENT,
	input wire logic               POWER_LIMIT_LOW,
	input wire logic               DATA_NOT_READY
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	// Raw low run of the reset pin; saturates
	logic [7:0] low_cnt_r;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST)
			low_cnt_r <= 8'h00;
		else if (MODULE_RESET_N)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hff)
			low_cnt_r <= low_cnt_r + 8'h01;
	end

	a_presence_grounded: assert property (PRESENCE_N_OE && !PRESENCE_N_OUT)
		else $error("presence line not pulled low");
	a_pins_open_drain: assert property (!ATTENTION_N_OUT && !SDA_OUT)
		else $error("open-drain line driven high");
	a_deselect_sda_free: assert property (MODULE_SELECT_N [*8] |-> !SDA_OE)
		else $error("data line held while deselected");
	a_deselect_keeps_attn: assert property
		((ATTENTION_N_OE && MODULE_SELECT_N && MODULE_RESET_N) [*8] |=> ATTENTION_N_OE)
		else $error("attention dropped while deselected");
	a_done_posts_attn: assert property ($fell(DATA_NOT_READY) |-> ##[1:3] ATTENTION_N_OE)
		else $error("no attention at init done");
	a_power_low_follows: assert property (LOW_POWER_SELECT [*7] |-> POWER_LIMIT_LOW)
		else $error("power limit not low");
	a_power_high_follows: assert property (!LOW_POWER_SELECT [*7] |-> !POWER_LIMIT_LOW)
		else $error("power limit not high");
	a_fault_posts_attn: assert property (FAULT_EVENT != '0 |-> ##[1:3] ATTENTION_N_OE)
		else $error("fault without attention");
	a_long_reset_wipes: assert property
		(int'(low_cnt_r) > RESET_MIN + 10 |-> DATA_NOT_READY && !ATTENTION_N_OE)
		else $error("long reset pulse not taken");
	a_short_reset_kept: assert property ($rose(DATA_NOT_READY) |-> int'(low_cnt_r) > RESET_MIN)
		else $error("wipe on short pulse");

	c_fault_attn: cover property (FAULT_EVENT != '0 ##2 ATTENTION_N_OE);
	c_init_done: cover property ($fell(DATA_NOT_READY));
	c_bus_ack: cover property (!MODULE_SELECT_N && $rose(SDA_OE));
endmodule : lsc_props

bind module_low_speed_control lsc_props #(.RESET_MIN(RESET_MIN)) lsc_props_inst (
	.CORE_CLK, .RST, .MODULE_SELECT_N, .MODULE_RESET_N, .LOW_POWER_SELECT, .SDA_OUT, .SDA_OE,
	.ATTENTION_N_OUT, .ATTENTION_N_OE, .PRESENCE_N_OUT, .PRESENCE_N_OE, .FAULT_EVENT,
	.POWER_LIMIT_LOW, .DATA_NOT_READY
);
`default_nettype wire

// >>> dv/test_module_low_speed_control.sv
// Self-checking bench for the module low-speed control block.
// Host pins change at the falling clock edge; the host model runs the bus.
`timescale 1ns/1ps
`default_nettype none
module test_module_low_speed_control import lsc_pkg::*;;
	localparam int      RMIN = 4;
	localparam int      INIT = 8;
	logic               clk, rst, sel_n, rst_n, lp, scl, host_n, a0, ack;
	logic               sda_out, sda_oe, att_out, att_oe, prs_out, prs_oe, plim, dnr;
	logic [FAULT_W-1:0] fault;
	logic [7:0]         rd, d;
	logic [6:0]         p;
	int                 errors, n_tests, seed, k;
	wire logic          sda = host_n & (sda_oe ? sda_out : 1'b1); // Pull-up

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	module_low_speed_control #(.DEV_ADDR(DEV_ADDR_DEFAULT), .RESET_MIN(RMIN), .INIT_TIME(INIT))
	module_low_speed_control_inst (
		.CORE_CLK(clk), .RST(rst), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(rst_n),
		.LOW_POWER_SELECT(lp), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.ATTENTION_N_OUT(att_out), .ATTENTION_N_OE(att_oe), .PRESENCE_N_OUT(prs_out),
		.PRESENCE_N_OE(prs_oe), .FAULT_EVENT(fault), .POWER_LIMIT_LOW(plim),
		.DATA_NOT_READY(dnr)
	);
	host_master host_master_inst (.scl(scl), .sda_drv_n(host_n), .sda(sda));

	task automatic final_report();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// One pointer write, then either a data byte or a restarted single read
	task automatic xfer(input logic [7:0] ptr, input logic rd_en, input logic [7:0] wd);
		host_master_inst.start();
		host_master_inst.byte_io({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rd, a0);
		check(8'(a0), 8'(sel_n));
		host_master_inst.byte_io(ptr, 1'b1, rd, ack);
		if (rd_en) begin
			host_master_inst.start();
			host_master_inst.byte_io({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rd, ack);
			host_master_inst.byte_io(8'hff, 1'b1, rd, ack);
		end else
			host_master_inst.byte_io(wd, 1'b1, rd, ack);
		host_master_inst.stop();
	endtask : xfer

	initial begin
		#400us;
		errors++;
		final_report();
	end

	initial begin
		seed = 24549;
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		sel_n = 1'b0; // Own select line for this module
		rst_n = 1'b1;
		lp = 1'b0;
		fault = '0;
		tick(3);
		rst = 1'b0;
		check(8'(dnr), 8'h01);
		check(8'({prs_oe, prs_out}), 8'h02);
		tick(INIT + 4);
		check(8'(att_oe), 8'h01);
		xfer(8'h02, 1'b1, 8'h00); // Status read after attention
		check(rd, 8'h00);
		xfer(8'h03, 1'b1, 8'h00);
		check(rd, 8'h01);
		check(8'(att_oe), 8'h00);
		// Write with pointer bit 7 set, read back without it
		for (int i = 0; i < 6; i++) begin
			p = (i == 0) ? 7'h7f : 7'(5 + {$random(seed)} % 123);
			d = 8'($random(seed));
			xfer({1'b1, p}, 1'b0, d);
			xfer({1'b0, p}, 1'b1, 8'h00);
			check(rd, d);
		end
		for (int i = 0; i < 4; i++) begin
			lp = 1'($random(seed));
			tick(8);
			check(8'(plim), 8'(lp));
		end
		lp = 1'b1;
		tick(8);
		xfer(8'h02, 1'b1, 8'h00);
		check(rd, 8'h02);
		k = {$random(seed)} % FAULT_W;
		tick(1);
		fault = FAULT_W'(1 << k);
		tick(1);
		fault = '0;
		tick(4);
		check(8'(att_oe), 8'h01);
		xfer({1'b0, FLAG_OFS}, 1'b0, 8'h00); // Flags clear on read only
		check(8'(att_oe), 8'h01);
		xfer({1'b0, MASK_OFS}, 1'b0, 8'hff);
		check(8'(att_oe), 8'h00);
		xfer({1'b0, MASK_OFS}, 1'b0, 8'h00);
		check(8'(att_oe), 8'h01);
		sel_n = 1'b1;
		xfer({1'b0, p}, 1'b0, ~d);
		check(8'(att_oe), 8'h01);
		tick(1);
		sel_n = 1'b0;
		tick(8);
		xfer({1'b0, p}, 1'b1, 8'h00);
		check(rd, d);
		xfer(8'h03, 1'b1, 8'h00);
		check(rd, 8'(2 << k));
		check(8'(att_oe), 8'h00);
		tick(1);
		rst_n = 1'b0;
		tick(RMIN - 1);
		rst_n = 1'b1;
		tick(8);
		check(8'(dnr), 8'h00);
		rst_n = 1'b0;
		tick(RMIN + 12);
		check(8'(dnr), 8'h01);
		rst_n = 1'b1;
		tick(INIT + 12);
		check(8'(att_oe), 8'h01);
		xfer({1'b0, p}, 1'b1, 8'h00);
		check(rd, 8'h00);
		final_report();
	end
endmodule : test_module_low_speed_control
`default_nettype wire
